// ### verilog/ebws_top.sv
`timescale 1ns/1ps
`default_nettype none
module ebws_top
  import ebws_pkg::*;
(
  input wire logic core_clk_in, // core clock, 100 MHz
  input wire logic rst_in, // async reset, active high
  input wire logic ce_in, // clock enable, freezes all state when low
  input wire logic endian_strap_in, // strap: 0 big, 1 little endian
  input wire logic reg_wr_in, // register write strobe
  input wire logic reg_rd_in, // register read strobe
  input wire logic [11:0] reg_addr_in, // register byte offset
  input wire logic [31:0] reg_wdata_in, // register write data
  input wire logic [2:0] path_in, // ebws_path_e one-hot beat source
  input wire logic tgt_swap_bar_in, // target hit is a swap bar
  input wire logic beat_valid_in, // beat qualifier
  input wire ebws_beat_s beat_in, // incoming beat
  output ebws_beat_s beat_out, // swapped beat, registered
  output logic beat_valid_out, // registered beat qualifier
  output logic [31:0] reg_rdata_out, // register read data
  output logic reg_rvalid_out, // read data valid pulse
  output logic [2:0] swap_state_out, // {pci tgt, pci mst, cpu} byte bits
  output logic little_endian_out // all byte bits high
);
  logic [31:0] cpu_setup_ff;
  logic [31:0] pci_swap_ff;
  logic [31:0] cfg_data_ff;
  logic [1:0] strap_cnt_ff;
  logic strap_win_ff;
  logic strap_ff;
  logic [31:0] nxt_cpu_setup;
  logic [31:0] nxt_pci_swap;

  default clocking core_cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);

  // the strap window keeps the sampled level following the pin
  // so a slow board pull still settles before software takes over
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      strap_cnt_ff <= 2'h0;
      strap_win_ff <= 1'b1;
    end else if (ce_in && strap_win_ff) begin
      strap_cnt_ff <= strap_cnt_ff + 2'h1;
      if (strap_cnt_ff == EBWS_STRAP_HOLD_CYC - 2'h1) begin
        strap_win_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      strap_ff <= 1'b0;
    end else if (ce_in && strap_win_ff) begin
      strap_ff <= endian_strap_in;
    end
  end

  wire logic hit_cpu;
  wire logic hit_pci;
  wire logic hit_cfg;
  assign hit_cpu = reg_addr_in == EBWS_OFS_CPU_SETUP;
  assign hit_pci = reg_addr_in == EBWS_OFS_PCI_SWAP;
  assign hit_cfg = reg_addr_in == EBWS_OFS_CFG_DATA;

  // while the window is open the byte bits follow the strap
  always_comb begin
    nxt_cpu_setup = cpu_setup_ff;
    nxt_pci_swap = pci_swap_ff;
    if (strap_win_ff) begin
      nxt_cpu_setup[EBWS_CPU_BSWAP_BIT] = endian_strap_in;
      nxt_pci_swap[EBWS_PCI_MBSWAP_BIT] = endian_strap_in;
      nxt_pci_swap[EBWS_PCI_TBSWAP_BIT] = endian_strap_in;
    end else if (reg_wr_in && hit_cpu) begin
      nxt_cpu_setup = reg_wdata_in;
    end else if (reg_wr_in && hit_pci) begin
      nxt_pci_swap = reg_wdata_in;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cpu_setup_ff <= EBWS_CPU_SETUP_RST;
      pci_swap_ff <= EBWS_PCI_SWAP_RST;
      cfg_data_ff <= EBWS_CFG_DATA_RST;
    end else if (ce_in) begin
      cpu_setup_ff <= nxt_cpu_setup;
      pci_swap_ff <= nxt_pci_swap;
      if (reg_wr_in && hit_cfg && !strap_win_ff) begin
        cfg_data_ff <= reg_wdata_in;
      end
    end
  end

  wire logic cpu_bit;
  wire logic mst_bit;
  wire logic tgt_bit;
  assign cpu_bit = cpu_setup_ff[EBWS_CPU_BSWAP_BIT];
  assign mst_bit = pci_swap_ff[EBWS_PCI_MBSWAP_BIT];
  assign tgt_bit = pci_swap_ff[EBWS_PCI_TBSWAP_BIT];

  wire logic [31:0] reg_mux;
  assign reg_mux = hit_cpu ? cpu_setup_ff :
                   hit_pci ? pci_swap_ff :
                   hit_cfg ? cfg_data_ff : 32'h0000_0000;

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= 32'h0000_0000;
      reg_rvalid_out <= 1'b0;
    end else if (ce_in) begin
      reg_rvalid_out <= reg_rd_in;
      reg_rdata_out <= reg_rd_in ? reg_mux : 32'h0000_0000;
    end
  end

  // swap decision per source; internal pci registers are never swapped
  // by the pci unit, cpu internal accesses are swapped only by cpu bit
  wire logic is_cpu;
  wire logic is_mst;
  wire logic is_tgt;
  assign is_cpu = path_in == EBWS_PATH_CPU;
  assign is_mst = path_in == EBWS_PATH_PCI_MST;
  assign is_tgt = path_in == EBWS_PATH_PCI_TGT;

  wire logic tgt_wbit;
  assign tgt_wbit = tgt_swap_bar_in ?
    pci_swap_ff[EBWS_PCI_TWSWAP_S_BIT] :
    pci_swap_ff[EBWS_PCI_TWSWAP_NS_BIT];

  wire logic do_bswap;
  wire logic do_wswap;
  assign do_bswap =
    (is_cpu && beat_in.internal && !cpu_bit) ||
    (is_mst && !beat_in.internal && !mst_bit) ||
    (is_tgt && !beat_in.internal && !tgt_bit);
  assign do_wswap =
    (is_mst && !beat_in.internal && pci_swap_ff[EBWS_PCI_MWSWAP_BIT]) ||
    (is_tgt && !beat_in.internal && tgt_wbit);

  wire logic [63:0] swapped;
  ebws_lane u_lane (
    .data_in(beat_in.data),
    .bswap_in(do_bswap),
    .wswap_in(do_wswap),
    .data_out(swapped)
  );

  // even address word: low word in little endian, high word in big
  wire logic big_mode;
  assign big_mode = !cpu_bit;

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      beat_out <= '0;
      beat_valid_out <= 1'b0;
      swap_state_out <= 3'h0;
      little_endian_out <= 1'b0;
    end else if (ce_in) begin
      beat_out.data <= swapped;
      beat_out.addr2 <= beat_in.addr2 ^ big_mode;
      beat_out.internal <= beat_in.internal;
      beat_valid_out <= beat_valid_in;
      swap_state_out <= {tgt_bit, mst_bit, cpu_bit};
      little_endian_out <= cpu_bit && mst_bit && tgt_bit;
    end
  end

  // reference reversals for the checks below, written apart from the lane
  function automatic logic [63:0] bytes_rev(input logic [63:0] d);
    bytes_rev = {d[39:32], d[47:40], d[55:48], d[63:56],
                 d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction
  function automatic logic [63:0] halves_swap(input logic [63:0] d);
    halves_swap = {d[31:0], d[63:32]};
  endfunction

  // strap window and register side
  a_strap_window: assert property (
    $fell(strap_win_ff) |-> $past(strap_cnt_ff) == EBWS_STRAP_HOLD_CYC - 2'h1)
    else $error("strap window closed at wrong count");
  a_strap_follow: assert property (
    ce_in && strap_win_ff |=> cpu_bit == $past(endian_strap_in))
    else $error("byte bit did not follow strap");
  a_strap_latched: assert property (
    $past(ce_in && strap_win_ff) |->
    {tgt_bit, mst_bit, cpu_bit} == {3{strap_ff}})
    else $error("byte bits differ from latched strap");
  a_window_blocks: assert property (
    ce_in && strap_win_ff |=> $stable(cfg_data_ff) &&
    $stable(pci_swap_ff[15:1]) && $stable(cpu_setup_ff[11:0]))
    else $error("register written inside strap window");
  a_setup_write: assert property (
    ce_in && !strap_win_ff && reg_wr_in && hit_cpu |=>
    cpu_setup_ff == $past(reg_wdata_in))
    else $error("setup write lost");
  a_swap_write: assert property (
    ce_in && !strap_win_ff && reg_wr_in && hit_pci |=>
    pci_swap_ff == $past(reg_wdata_in))
    else $error("swap command write lost");
  a_read_answer: assert property (
    ce_in && reg_rd_in && hit_pci |=>
    reg_rvalid_out && reg_rdata_out == $past(pci_swap_ff))
    else $error("swap command read wrong");
  a_state_out: assert property (
    ce_in |=> swap_state_out[0] == $past(cpu_bit) &&
    swap_state_out[2:1] == {$past(tgt_bit), $past(mst_bit)})
    else $error("swap state output stale");
  a_little_out: assert property (
    ce_in |=> little_endian_out ==
    ($past(cpu_bit) && $past(mst_bit) && $past(tgt_bit)))
    else $error("little endian flag wrong");
  a_ce_freeze: assert property (
    !ce_in |=> $stable(cpu_setup_ff) && $stable(pci_swap_ff) &&
    $stable(cfg_data_ff) && $stable(beat_out) && $stable(strap_win_ff))
    else $error("state moved while clock enable low");

  // data path, one source at a time
  a_little_none: assert property (
    cpu_bit && mst_bit && tgt_bit |-> !do_bswap)
    else $error("byte swap in little endian mode");
  a_cpu_internal: assert property (
    is_cpu && beat_in.internal && !cpu_bit &&
    beat_in.data[31:0] == 32'h0403_0201 |-> swapped[31:0] == 32'h0102_0304)
    else $error("internal read not byte swapped");
  a_cpu_words: assert property (
    is_cpu && beat_in.internal && !cpu_bit |->
    swapped == bytes_rev(beat_in.data))
    else $error("processor internal data not reversed");
  a_cpu_pass: assert property (
    is_cpu && cpu_bit |-> swapped == beat_in.data)
    else $error("processor data swapped with setup bit high");
  a_cpu_memory: assert property (
    is_cpu && !beat_in.internal |-> swapped == beat_in.data)
    else $error("memory data altered");
  a_pci_own_reg: assert property (
    (is_mst || is_tgt) && beat_in.internal |-> swapped == beat_in.data)
    else $error("pci own register swapped");
  a_mst_bswap: assert property (
    is_mst && !beat_in.internal && !mst_bit &&
    !pci_swap_ff[EBWS_PCI_MWSWAP_BIT] |-> swapped == bytes_rev(beat_in.data))
    else $error("master data not byte swapped");
  a_mst_both: assert property (
    is_mst && !beat_in.internal && !mst_bit &&
    pci_swap_ff[EBWS_PCI_MWSWAP_BIT] |->
    swapped == halves_swap(bytes_rev(beat_in.data)))
    else $error("master byte then word swap wrong");
  a_mst_wswap: assert property (
    is_mst && !beat_in.internal && mst_bit &&
    pci_swap_ff[EBWS_PCI_MWSWAP_BIT] |-> swapped == halves_swap(beat_in.data))
    else $error("master word swap missing");
  a_pci_no_bswap: assert property (
    is_mst && mst_bit && !pci_swap_ff[EBWS_PCI_MWSWAP_BIT] |->
    swapped == beat_in.data)
    else $error("master data changed with swapping off");
  a_tgt_bswap: assert property (
    is_tgt && !beat_in.internal && !tgt_bit && !tgt_wbit |->
    swapped == bytes_rev(beat_in.data))
    else $error("target data not byte swapped");
  a_tgt_nobyte: assert property (
    is_tgt && tgt_bit && !tgt_wbit |-> swapped == beat_in.data)
    else $error("target data changed with swapping off");
  a_tgt_ns_word: assert property (
    is_tgt && !beat_in.internal && tgt_bit && !tgt_swap_bar_in &&
    pci_swap_ff[EBWS_PCI_TWSWAP_NS_BIT] |->
    swapped == halves_swap(beat_in.data))
    else $error("non-swap bar word swap missing");
  a_tgt_s_word: assert property (
    is_tgt && !beat_in.internal && tgt_bit && tgt_swap_bar_in &&
    pci_swap_ff[EBWS_PCI_TWSWAP_S_BIT] |->
    swapped == halves_swap(beat_in.data))
    else $error("swap bar word swap missing");
  a_tgt_bar_sel: assert property (
    is_tgt && !beat_in.internal && tgt_bit && tgt_swap_bar_in &&
    !pci_swap_ff[EBWS_PCI_TWSWAP_S_BIT] |-> swapped == beat_in.data)
    else $error("swap bar word swap wrong");
  a_addr_word: assert property (
    ce_in |=> beat_out.addr2 == ($past(beat_in.addr2) ^ !$past(cpu_bit)))
    else $error("word index wrong");
  a_valid_pass: assert property (
    ce_in |=> beat_valid_out == $past(beat_valid_in))
    else $error("beat qualifier not passed in one cycle");
  a_beat_latency: assert property (
    ce_in |=> beat_out.data == $past(swapped))
    else $error("beat not passed in one cycle");
endmodule // ebws_top
`default_nettype wire

// ### common/ebws_pkg.sv
package ebws_pkg;
  // register offsets (byte addresses)
  localparam logic [11:0] EBWS_OFS_CPU_SETUP = 12'h000;
  localparam logic [11:0] EBWS_OFS_PCI_SWAP = 12'hC00;
  localparam logic [11:0] EBWS_OFS_CFG_DATA = 12'hCFC;
  // field positions
  localparam int EBWS_CPU_BSWAP_BIT = 12;
  localparam int EBWS_PCI_MBSWAP_BIT = 0;
  localparam int EBWS_PCI_MWSWAP_BIT = 10;
  localparam int EBWS_PCI_TWSWAP_NS_BIT = 11;
  localparam int EBWS_PCI_TWSWAP_S_BIT = 12;
  localparam int EBWS_PCI_TBSWAP_BIT = 16;
  // reset values of the non-strap bits
  localparam logic [31:0] EBWS_CPU_SETUP_RST = 32'h0000_0000;
  localparam logic [31:0] EBWS_PCI_SWAP_RST = 32'h0000_0000;
  localparam logic [31:0] EBWS_CFG_DATA_RST = 32'h0000_0000;
  // strap sampling window after reset release, in core clocks
  localparam logic [1:0] EBWS_STRAP_HOLD_CYC = 2'h3;

  typedef struct packed {
    logic [63:0] data;
    logic addr2;
    logic internal;
  } ebws_beat_s;

  typedef enum logic [2:0] {
    EBWS_PATH_CPU = 3'h1,
    EBWS_PATH_PCI_MST = 3'h2,
    EBWS_PATH_PCI_TGT = 3'h4
  } ebws_path_e;
endpackage

// ### verilog/ebws_lane.sv
`timescale 1ns/1ps
`default_nettype none
module ebws_lane
  import ebws_pkg::*;
(
  input wire logic [63:0] data_in, // beat before swapping
  input wire logic bswap_in, // reverse bytes in each word
  input wire logic wswap_in, // exchange 32-bit halves
  output logic [63:0] data_out // beat after swapping
);
  function automatic logic [31:0] ebws_rev4(input logic [31:0] w);
    ebws_rev4 = {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction
  wire logic [63:0] byte_stage;
  assign byte_stage = bswap_in ?
    {ebws_rev4(data_in[63:32]), ebws_rev4(data_in[31:0])} : data_in;
  assign data_out = wswap_in ?
    {byte_stage[31:0], byte_stage[63:32]} : byte_stage;
endmodule // ebws_lane
`default_nettype wire

// ### verification/ebws_far_agent.sv
`timescale 1ns/1ps
`default_nettype none
module ebws_far_agent
  import ebws_pkg::*;
(
  input wire logic clk_in, // core clock
  output logic strap_out, // board endian strap
  output logic [2:0] path_out, // beat source
  output logic bar_out, // target hit is a swap bar
  output logic valid_out, // beat qualifier
  output ebws_beat_s beat_out // beat toward the block
);
  initial begin
    strap_out = 1'b0;
    path_out = 3'h0;
    bar_out = 1'b0;
    valid_out = 1'b0;
    beat_out = '0;
  end
  task automatic strap(input logic v);
    strap_out = v;
  endtask
  task automatic send(input logic [2:0] p, input logic b, input ebws_beat_s d);
    path_out = p;
    bar_out = b;
    beat_out = d;
    valid_out = 1'b1;
    @(posedge clk_in);
    #1;
  endtask
  // released data flips so a stale beat never looks current
  task automatic idle();
    valid_out = 1'b0;
    beat_out.data = ~beat_out.data;
  endtask
endmodule // ebws_far_agent
`default_nettype wire

// ### verification/endian_byte_word_swap_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
  begin \
    check_count++; \
    if ((g) !== (e)) begin \
      err_total++; \
      $display("mismatch at %0t: got %h exp %h", $time, g, e); \
    end \
  end
module endian_byte_word_swap_test
  import ebws_pkg::*;
;
  logic core_clk_in, rst_in, reg_wr_in, reg_rd_in, bvo, rv, le, b, ce;
  logic [11:0] reg_addr_in;
  logic [31:0] reg_wdata_in, su, pc, rdat, er;
  logic [2:0] sst, p;
  wire logic strap, bar, bv;
  wire logic [2:0] path;
  wire ebws_beat_s bin;
  ebws_beat_s bout, eb, d;
  ebws_beat_s bq[$];
  logic [31:0] rq[$];
  int err_total, check_count, cyc, seed;

  ebws_far_agent agent (.clk_in(core_clk_in), .strap_out(strap),
    .path_out(path), .bar_out(bar), .valid_out(bv), .beat_out(bin));
  ebws_top dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .ce_in(ce),
    .endian_strap_in(strap), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .path_in(path),
    .tgt_swap_bar_in(bar), .beat_valid_in(bv), .beat_in(bin),
    .beat_out(bout), .beat_valid_out(bvo), .reg_rdata_out(rdat),
    .reg_rvalid_out(rv), .swap_state_out(sst), .little_endian_out(le));

  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end

  function automatic logic [31:0] rv4(input logic [31:0] w);
    return {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction

  function automatic ebws_beat_s xp(input logic [2:0] p, input logic b,
                                    input ebws_beat_s d);
    logic bs, ws;
    ebws_beat_s r;
    bs = (p == 3'h1) ? d.internal & ~su[12] :
      (p == 3'h2) ? ~d.internal & ~pc[0] :
      (p == 3'h4) ? ~d.internal & ~pc[16] : 1'b0;
    ws = ~d.internal & ((p == 3'h2) ? pc[10] :
      (p == 3'h4) ? (b ? pc[12] : pc[11]) : 1'b0);
    r = d;
    if (bs)
      r.data = {rv4(d.data[63:32]), rv4(d.data[31:0])};
    if (ws)
      r.data = {r.data[31:0], r.data[63:32]};
    r.addr2 = d.addr2 ^ ~su[12];
    return r;
  endfunction

  task automatic step();
    @(posedge core_clk_in);
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    reg_wr_in = 1'b1;
    reg_addr_in = a;
    reg_wdata_in = v;
    step();
    reg_wr_in = 1'b0;
    step();
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] v);
    rq.push_back(v);
    reg_rd_in = 1'b1;
    reg_addr_in = a;
    step();
    reg_rd_in = 1'b0;
    step();
  endtask
  task automatic rst(input logic v);
    agent.strap(v);
    rst_in = 1'b1;
    repeat (2) step();
    rst_in = 1'b0;
    step();
    // lands inside the strap window, so it must be dropped
    wr(12'hC00, 32'hFFFF_FFFF);
    rd(12'h000, {19'h0, v, 12'h0});
    rd(12'hC00, {15'h0, v, 15'h0, v});
    `CHK(sst, {3{v}})
    `CHK(le, v)
  endtask
  task automatic finish_test();
    if (err_total == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(negedge core_clk_in) begin
    if (bvo === 1'b1) begin
      eb = bq.pop_front();
      `CHK(bout, eb)
    end
    if (rv === 1'b1) begin
      er = rq.pop_front();
      `CHK(rdat, er)
    end
  end
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc > 3000) begin
      err_total++;
      finish_test();
    end
  end

  initial begin
    rst_in = 1'b1;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reg_addr_in = 12'h000;
    reg_wdata_in = 32'h0;
    ce = 1'b1;
    seed = 32'h96825DFE;
    rst(1'b0);
    su = $random(seed);
    wr(12'hCFC, su);
    // a frozen core must not take this write
    ce = 1'b0;
    wr(12'hCFC, ~su);
    ce = 1'b1;
    rd(12'hCFC, su);
    rd(12'h004, 32'h0);
    for (int k = 0; k < 16; k++) begin
      su = $random(seed);
      pc = $random(seed);
      su[12] = k[0];
      pc[0] = k[1];
      pc[16] = k[2];
      pc[10] = k[3];
      wr(12'h000, su);
      wr(12'hC00, pc);
      rd(12'h000, su);
      rd(12'hC00, pc);
      for (int j = 0; j < 8; j++) begin
        d.data = {$random(seed), $random(seed)};
        if (j == 0)
          d.data[31:0] = 32'h0403_0201;
        d.addr2 = seed[3];
        d.internal = seed[7];
        b = seed[11];
        p = (j == 7) ? 3'h3 : 3'h1 << (j % 3);
        bq.push_back(xp(p, b, d));
        agent.send(p, b, d);
      end
      agent.idle();
      step();
    end
    rst(1'b1);
    step();
    `CHK(bq.size(), 0)
    `CHK(rq.size(), 0)
    finish_test();
  end
endmodule // endian_byte_word_swap_test
`default_nettype wire
